// ===== common/pcs_pkg.sv
// program flow unit package: register indices, field layout, reset values,
// phase states and the decoder command carrier.
// assumes the core decoder drives one command per instruction cycle.
package pcs_pkg;

  // ****************************************************************
  // register map (word index on the plain register port)
  // ****************************************************************
  localparam logic [1:0] REG_PC_LOW_BYTE         = 2'h0;
  localparam logic [1:0] REG_EXEC_ADDR_READ_LOW  = 2'h1;
  localparam logic [1:0] REG_EXEC_ADDR_READ_HIGH = 2'h2;
  localparam logic [1:0] REG_STACK_POINTER_STAT  = 2'h3;

  // ****************************************************************
  // field layout and widths
  // ****************************************************************
  localparam int PC_W            = 13;
  localparam int STK_PTR_W       = 3;
  localparam int STK_DEPTH       = 8;
  localparam int OVF_BIT         = 7;
  localparam int HIGH_ADDR_W     = 5;
  localparam logic [3:0] STK_FULL_CNT = 4'h8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [12:0] PC_RESET_VEC  = 13'h0000;
  localparam logic [2:0]  STK_PTR_RESET = 3'h0;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // ****************************************************************
  // instruction phases
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_FETCH,
    PH_DECODE,
    PH_EXEC,
    PH_WRITE
  } pcs_phase_t;

  // ****************************************************************
  // decoder command, sampled at the end of the last phase
  // ****************************************************************
  typedef struct packed {
    logic        jump_instr;              // load target, no push
    logic        call_instr;              // push then load target
    logic        irq_ack_req;             // interrupt vector request
    logic        subroutine_return_instr; // pop
    logic        interrupt_return_instr;  // pop
    logic        skip_taken;              // conditional skip met
    logic [12:0] target;                  // jump or vector address
  } pcs_cmd_t;

  typedef struct packed {
    logic carry;
    logic borrow;
    logic zero;
    logic overflow;
  } pcs_alu_flags_t;

endpackage

// ===== logic/pcs_prog_flow.sv
// program counter, execution address read pair and 8-level return stack.
// assumes the decoder command and alu flags are stable across the last
// phase of an instruction cycle and register strobes are one cycle long.
// the stack array has no reset: a pop of an empty stack returns whatever
// the slot last held, which software must treat as undefined.
`timescale 1ns/10ps

module pcs_prog_flow (
  input  wire logic                    clock_i,       // 50 MHz core clock
  input  wire logic                    rst_b_i,       // async reset, active low
  input  wire logic                    clk_en_i,      // freezes all state when low
  input  wire logic [1:0]              reg_addr_i,    // register index
  input  wire logic [7:0]              reg_wdata_i,   // write data
  input  wire logic                    reg_wr_i,      // write strobe
  input  wire logic                    reg_rd_i,      // read strobe
  output logic      [7:0]              reg_rdata_o,   // read data, next cycle
  input  wire pcs_pkg::pcs_cmd_t       cmd_i,         // decoder command
  input  wire logic                    irq_pend_i,    // enabled interrupt pending
  input  wire logic                    alu_valid_i,   // alu result this cycle
  input  wire pcs_pkg::pcs_alu_flags_t alu_flags_i,   // alu status flags
  output logic      [12:0]             fetch_addr_o,  // program memory address
  output logic                         fetch_o,       // fetch in this phase
  output logic                         idle_cycle_o,  // current cycle is idle
  output logic                         irq_ack_o,     // interrupt acknowledge
  output logic      [1:0]              phase_o,       // current phase
  output pcs_pkg::pcs_alu_flags_t      status_o       // status register
);

  // ****************************************************************
  // state
  // ****************************************************************
  pcs_pkg::pcs_phase_t     phase_r;
  pcs_pkg::pcs_phase_t     phase_nxt;
  logic [12:0]             pc_r;
  logic [12:0]             pc_nxt;
  logic [12:0]             exec_addr_r;
  logic [12:0]             exec_addr_nxt;
  logic [12:0]             stack_mem_r [pcs_pkg::STK_DEPTH];
  logic [2:0]              stk_ptr_r;
  logic [2:0]              stk_ptr_nxt;
  logic [3:0]              stk_cnt_r;
  logic [3:0]              stk_cnt_nxt;
  logic                    ovf_r;
  logic                    ovf_nxt;
  logic [7:0]              high_buf_r;
  logic [7:0]              rdata_r;
  logic [7:0]              rdata_nxt;
  logic                    idle_r;
  logic                    idle_nxt;
  logic                    irq_ack_r;
  logic                    fetch_r;
  pcs_pkg::pcs_alu_flags_t status_r;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [12:0] pc_inc(input logic [12:0] v);
    pc_inc = v + 13'h0001;
  endfunction

  // low byte replaced, page bits kept: the only jump software can make
  function automatic logic [12:0] page_jump(input logic [12:0] v,
                                            input logic [7:0]  lo);
    page_jump = {v[12:8], lo};
  endfunction

  function automatic logic reg_hit(input logic [1:0] a,
                                   input logic [1:0] idx);
    reg_hit = (a == idx);
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic end_of_cycle = clk_en_i && (phase_r == pcs_pkg::PH_WRITE);
  wire logic stk_full     = (stk_cnt_r == pcs_pkg::STK_FULL_CNT);
  wire logic stk_empty    = (stk_cnt_r == 4'h0);

  // ****************************************************************
  // register port decode
  // ****************************************************************
  // the master never raises both strobes, so the hits need no priority
  wire logic wr_pcl       = reg_wr_i && reg_hit(reg_addr_i, pcs_pkg::REG_PC_LOW_BYTE);
  wire logic wr_stk       = reg_wr_i && reg_hit(reg_addr_i, pcs_pkg::REG_STACK_POINTER_STAT);
  wire logic rd_low       = reg_rd_i && reg_hit(reg_addr_i, pcs_pkg::REG_EXEC_ADDR_READ_LOW);

  // ****************************************************************
  // command decode
  // ****************************************************************
  // an idle cycle executes nothing, so its command is ignored
  wire logic live         = end_of_cycle && !idle_r;
  wire logic do_call      = live && cmd_i.call_instr;
  // acknowledge is held back while all eight levels are in use
  wire logic do_irq       = live && cmd_i.irq_ack_req && irq_pend_i && !stk_full;
  wire logic do_push      = do_call || do_irq;
  wire logic do_pop       = live && !do_push &&
                            (cmd_i.subroutine_return_instr || cmd_i.interrupt_return_instr);
  wire logic do_jump      = live && !do_push && !do_pop && cmd_i.jump_instr;
  wire logic do_skip      = live && cmd_i.skip_taken;
  wire logic [2:0] pop_ptr = stk_ptr_r - 3'h1;
  wire logic [2:0] push_ptr = stk_ptr_r + 3'h1;
  wire logic [3:0] cnt_up   = stk_cnt_r + 4'h1;
  wire logic [3:0] cnt_dn   = stk_cnt_r - 4'h1;

  // ****************************************************************
  // pc candidates
  // ****************************************************************
  wire logic [12:0] pc_seq  = pc_inc(pc_r);
  wire logic [12:0] pc_page = page_jump(pc_r, reg_wdata_i);
  wire logic [12:0] pc_pop  = stack_mem_r[pop_ptr];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      pcs_pkg::PH_FETCH:  phase_nxt = pcs_pkg::PH_DECODE;
      pcs_pkg::PH_DECODE: phase_nxt = pcs_pkg::PH_EXEC;
      pcs_pkg::PH_EXEC:   phase_nxt = pcs_pkg::PH_WRITE;
      pcs_pkg::PH_WRITE:  phase_nxt = pcs_pkg::PH_FETCH;
      default:            phase_nxt = pcs_pkg::PH_FETCH;
    endcase
  end

  // an idle cycle still steps the pc: the word it discarded is followed
  // by the one the pipeline really wants next
  always_comb begin
    pc_nxt        = pc_r;
    exec_addr_nxt = exec_addr_r;
    idle_nxt      = idle_r;
    if (end_of_cycle) begin
      exec_addr_nxt = pc_r;
      idle_nxt      = 1'b0;
      if (do_push) begin
        pc_nxt   = cmd_i.target;
        idle_nxt = 1'b1;
      end else if (do_pop) begin
        pc_nxt   = pc_pop;
        idle_nxt = 1'b1;
      end else if (do_jump) begin
        pc_nxt   = cmd_i.target;
        idle_nxt = 1'b1;
      end else if (wr_pcl) begin
        // page bits stay, so the jump cannot leave the 256-word page
        pc_nxt   = pc_page;
        idle_nxt = 1'b1;
      end else if (do_skip) begin
        pc_nxt   = pc_seq;
        idle_nxt = 1'b1;
      end else begin
        pc_nxt   = pc_seq;
      end
    end else if (clk_en_i && wr_pcl) begin
      pc_nxt   = pc_page;
      idle_nxt = 1'b1;
    end
  end

  // a call on a full stack still wraps the pointer and overwrites the
  // oldest slot; the count saturates at eight so full stays full
  always_comb begin
    stk_ptr_nxt = stk_ptr_r;
    stk_cnt_nxt = stk_cnt_r;
    ovf_nxt     = ovf_r;
    if (clk_en_i && wr_stk) begin
      ovf_nxt = reg_wdata_i[pcs_pkg::OVF_BIT];
    end
    // the hardware set below comes last, so it beats a same-cycle clear
    if (do_push) begin
      stk_ptr_nxt = push_ptr;
      if (stk_full) begin
        ovf_nxt = 1'b1;
      end else begin
        stk_cnt_nxt = cnt_up;
      end
    end else if (do_pop) begin
      stk_ptr_nxt = pop_ptr;
      if (stk_empty) begin
        ovf_nxt = 1'b1;
      end else begin
        stk_cnt_nxt = cnt_dn;
      end
    end
  end

  // ****************************************************************
  // register read mux
  // ****************************************************************
  wire logic [7:0] pcl_view  = pc_r[7:0];
  wire logic [7:0] low_view  = exec_addr_r[7:0];
  wire logic [7:0] high_view = high_buf_r;
  // status byte: flag on top, unused middle bits read as zero
  wire logic [7:0] stk_view  = {ovf_r, 4'h0, stk_ptr_r};

  always_comb begin
    rdata_nxt = pcs_pkg::BYTE_RESET;
    if (reg_rd_i) begin
      case (reg_addr_i)
        pcs_pkg::REG_PC_LOW_BYTE:         rdata_nxt = pcl_view;
        pcs_pkg::REG_EXEC_ADDR_READ_LOW:  rdata_nxt = low_view;
        pcs_pkg::REG_EXEC_ADDR_READ_HIGH: rdata_nxt = high_view;
        pcs_pkg::REG_STACK_POINTER_STAT:  rdata_nxt = stk_view;
        default:                          rdata_nxt = pcs_pkg::BYTE_RESET;
      endcase
    end
  end

  // ****************************************************************
  // sequencer flops
  // ****************************************************************
  // every register holds still while clk_en_i is low, so a stalled core
  // resumes in the very phase it stopped in
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= pcs_pkg::PH_FETCH;
    end else if (clk_en_i) begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_r <= pcs_pkg::PC_RESET_VEC;
    end else if (clk_en_i) begin
      pc_r <= pc_nxt;
    end
  end

  // the execution address trails the pc by one instruction cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exec_addr_r <= pcs_pkg::PC_RESET_VEC;
    end else if (clk_en_i) begin
      exec_addr_r <= exec_addr_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_r <= 1'b0;
    end else if (clk_en_i) begin
      idle_r <= idle_nxt;
    end
  end

  // ****************************************************************
  // stack flops
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stk_ptr_r <= pcs_pkg::STK_PTR_RESET;
    end else if (clk_en_i) begin
      stk_ptr_r <= stk_ptr_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stk_cnt_r <= 4'h0;
    end else if (clk_en_i) begin
      stk_cnt_r <= stk_cnt_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovf_r <= 1'b0;
    end else if (clk_en_i) begin
      ovf_r <= ovf_nxt;
    end
  end

  // no reset on the array: a pop of an empty stack reads a slot that may never have been pushed
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      stack_mem_r[stk_ptr_r] <= pc_r;
    end
  end

  // ****************************************************************
  // register port flops
  // ****************************************************************
  // the buffer moves only on a low read, so a late high read still pairs
  // with the low byte that software saw
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_buf_r <= pcs_pkg::BYTE_RESET;
    end else if (clk_en_i) begin
      if (rd_low) begin
        high_buf_r <= {3'h0, exec_addr_r[12:8]};
      end
    end
  end

  // zero except in the cycle after a read strobe
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= pcs_pkg::BYTE_RESET;
    end else if (clk_en_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // core-side flops
  // ****************************************************************
  // one pulse per taken interrupt; the decoder vectors on it
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_ack_r <= 1'b0;
    end else if (clk_en_i) begin
      irq_ack_r <= do_irq;
    end
  end

  // marks the first phase, in which the next word is fetched
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_r <= 1'b0;
    end else if (clk_en_i) begin
      fetch_r <= end_of_cycle;
    end
  end

  // ****************************************************************
  // status flops
  // ****************************************************************
  // flags move only on a live cycle, so an idle cycle leaves them alone
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= '0;
    end else if (clk_en_i) begin
      if (alu_valid_i && live) begin
        status_r <= alu_flags_i;
      end
    end
  end

  // ****************************************************************
  // outputs: each one is a flop above
  // ****************************************************************
  assign reg_rdata_o  = rdata_r;
  assign fetch_addr_o = pc_r;
  assign fetch_o      = fetch_r;
  assign idle_cycle_o = idle_r;
  assign irq_ack_o    = irq_ack_r;
  assign phase_o      = phase_r;
  assign status_o     = status_r;

endmodule

// ===== dv/pcs_decoder_model.sv
// decoder stand-in: presents the command the bench asks for.
// assumes phase_i is the unit's registered phase output.
`timescale 1ns/10ps
module pcs_decoder_model (
  input  wire logic [1:0]        phase_i, // unit phase
  input  wire pcs_pkg::pcs_cmd_t req_i,   // command wanted by the bench
  output pcs_pkg::pcs_cmd_t      cmd_o    // command bus to the unit
);
  // ****
  // drive
  // ****
  // outside the sampling phase the bus carries the inverse, so early sampling shows
  assign cmd_o = (phase_i == 2'h3) ? req_i : ~req_i;
endmodule

// ===== dv/pcs_prog_flow_monitor.sv
// checker for phase order, pc updates and register reads of the flow unit.
// assumes a bind onto pcs_prog_flow; sees its ports only.
`timescale 1ns/10ps
module pcs_prog_flow_monitor (
  input wire logic              clock_i,      // core clock
  input wire logic              rst_b_i,      // reset, active low
  input wire logic              clk_en_i,     // clock enable
  input wire logic [1:0]        reg_addr_i,   // register index
  input wire logic [7:0]        reg_wdata_i,  // write data
  input wire logic              reg_wr_i,     // write strobe
  input wire logic              reg_rd_i,     // read strobe
  input wire logic [7:0]        reg_rdata_o,  // read data
  input wire pcs_pkg::pcs_cmd_t cmd_i,        // decoder command
  input wire logic              irq_pend_i,   // interrupt pending
  input wire logic [12:0]       fetch_addr_o, // pc
  input wire logic              fetch_o,      // fetch pulse
  input wire logic              idle_cycle_o, // idle cycle
  input wire logic              irq_ack_o,    // interrupt acknowledge
  input wire logic [1:0]        phase_o       // phase
);
  // ****
  // checks
  // ****
  wire logic take_w = clk_en_i && phase_o == 2'h3 && !idle_cycle_o;
  wire logic flow_w = cmd_i.call_instr || cmd_i.irq_ack_req || cmd_i.subroutine_return_instr
                      || cmd_i.interrupt_return_instr || irq_pend_i;
  wire logic busy_w = flow_w || cmd_i.jump_instr || reg_wr_i;
  wire logic pcl_w  = clk_en_i && reg_wr_i && reg_addr_i == pcs_pkg::REG_PC_LOW_BYTE
                      && phase_o != 2'h3;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  AST_PHASE_WRAP: assert property (clk_en_i && phase_o == 2'h3 |=> phase_o == 2'h0 && fetch_o)
    else $error("phase did not wrap to fetch");
  AST_FETCH_PH0: assert property (fetch_o |-> phase_o == 2'h0)
    else $error("fetch outside first phase");
  AST_INC: assert property (take_w && !busy_w && !cmd_i.skip_taken
    |=> fetch_addr_o == $past(fetch_addr_o) + 13'h0001)
    else $error("pc not incremented");
  AST_JUMP: assert property (take_w && cmd_i.jump_instr && !flow_w
    |=> fetch_addr_o == $past(cmd_i.target))
    else $error("jump target not loaded");
  AST_CALL: assert property (take_w && cmd_i.call_instr
    |=> fetch_addr_o == $past(cmd_i.target) && idle_cycle_o)
    else $error("call target not loaded");
  AST_SKIP: assert property (take_w && cmd_i.skip_taken && !busy_w |=> idle_cycle_o)
    else $error("skip without idle cycle");
  AST_PCL_PAGE: assert property (pcl_w
    |=> fetch_addr_o == {$past(fetch_addr_o[12:8]), $past(reg_wdata_i)})
    else $error("low byte write left page");
  AST_PCL_IDLE: assert property (pcl_w |=> idle_cycle_o)
    else $error("low byte write without idle");
  AST_RO_WRITE: assert property (clk_en_i && reg_wr_i && reg_addr_i inside {2'h1, 2'h2}
    && phase_o == 2'h1 |=> $stable(fetch_addr_o))
    else $error("read-only write moved pc");
  AST_HIGH_ZERO: assert property (clk_en_i && reg_rd_i && reg_addr_i == 2'h2
    |=> reg_rdata_o[7:5] == 3'h0)
    else $error("high read upper bits set");
  AST_ACK_PULSE: assert property (irq_ack_o |-> phase_o == 2'h0 ##1 !irq_ack_o)
    else $error("acknowledge not a phase-0 pulse");
  COV_CALL: cover property (take_w && cmd_i.call_instr);
  COV_PCL: cover property (pcl_w);
  COV_ACK: cover property (irq_ack_o);
endmodule

// ===== dv/testbench.sv
// bench: register port tasks and decoder commands with expected values.
// assumes the package, the unit, its monitor and the decoder model compile first.
`timescale 1ns/10ps
module testbench;
  logic                    clock_i     = 1'b0;
  logic                    rst_b_i     = 1'b0;
  logic                    clk_en_i    = 1'b1;
  logic [1:0]              reg_addr_i  = 2'h0;
  logic [7:0]              reg_wdata_i = 8'h00;
  logic                    reg_wr_i    = 1'b0;
  logic                    reg_rd_i    = 1'b0;
  logic                    irq_pend_i  = 1'b0;
  logic                    alu_valid_i = 1'b0;
  pcs_pkg::pcs_alu_flags_t alu_flags_i = '0;
  pcs_pkg::pcs_cmd_t       req         = '0;
  pcs_pkg::pcs_cmd_t       cmd_w;
  pcs_pkg::pcs_alu_flags_t status_o;
  logic [12:0]             fetch_addr_o, p;
  logic [7:0]              reg_rdata_o, v;
  logic [1:0]              phase_o;
  logic                    fetch_o, idle_cycle_o, irq_ack_o;
  int                      n_errors = 0;
  int                      tests_run = 0;
  int                      i;
  localparam logic [1:0]   STK = pcs_pkg::REG_STACK_POINTER_STAT;
  // ****
  // harness
  // ****
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  pcs_decoder_model dec (.phase_i(phase_o), .req_i(req), .cmd_o(cmd_w));
  pcs_prog_flow uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_w), .irq_pend_i(irq_pend_i),
    .alu_valid_i(alu_valid_i), .alu_flags_i(alu_flags_i), .fetch_addr_o(fetch_addr_o),
    .fetch_o(fetch_o), .idle_cycle_o(idle_cycle_o), .irq_ack_o(irq_ack_o),
    .phase_o(phase_o), .status_o(status_o));
  task automatic report_and_stop;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    rd(a, v);
    chk({5'h00, v}, {5'h00, e});
  endtask
  // writes land in phase 1, clear of the phase-3 command edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    do @(posedge clock_i); while (phase_o !== 2'h0);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  // flags: jump, call, irq, return, interrupt return, skip; held until a non-idle take
  task automatic op(input logic [5:0] f, input logic [12:0] t);
    @(posedge clock_i);
    req <= pcs_pkg::pcs_cmd_t'({f, t});
    do @(posedge clock_i); while (phase_o !== 2'h3 || idle_cycle_o !== 1'b0);
    req <= '0;
    #1;
  endtask
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rchk(STK, 8'h00);
    // fill and drain first so that later empty returns pop defined entries
    for (i = 0; i < 16; i++) op(i < 8 ? 6'h10 : 6'h04, 13'h0100);
    for (i = 1; i <= 8; i++) begin
      op(i[0] ? 6'h04 : 6'h02, 13'h0000);
      rchk(STK, {1'b1, 4'h0, 3'(8 - i)});
    end
    wr(STK, 8'h07);
    rchk(STK, 8'h00);
    op(6'h20, 13'h1123);
    chk(fetch_addr_o, 13'h1123);
    op(6'h01, 13'h0000);
    chk({12'h000, idle_cycle_o}, 13'h0001);
    op(6'h00, 13'h0000);
    p = fetch_addr_o;
    @(posedge clock_i);
    alu_valid_i <= 1'b1;
    alu_flags_i <= 4'hA;
    op(6'h00, 13'h0000);
    chk(fetch_addr_o, p + 13'h0001);
    chk(13'(status_o), 13'h000A);
    rd(pcs_pkg::REG_EXEC_ADDR_READ_LOW, v);
    chk(13'(v[7:4]), 13'h0002);
    op(6'h20, 13'h0050);
    rchk(pcs_pkg::REG_EXEC_ADDR_READ_HIGH, 8'h11);
    wr(pcs_pkg::REG_PC_LOW_BYTE, 8'h5A);
    chk(fetch_addr_o, 13'h005A);
    chk({12'h000, idle_cycle_o}, 13'h0001);
    rchk(pcs_pkg::REG_PC_LOW_BYTE, 8'h5A);
    wr(pcs_pkg::REG_EXEC_ADDR_READ_LOW, 8'hFF);
    wr(pcs_pkg::REG_EXEC_ADDR_READ_HIGH, 8'hFF);
    for (i = 1; i <= 9; i++) begin
      if (i == 9) begin
        @(posedge clock_i);
        irq_pend_i <= 1'b1;
        op(6'h08, 13'h0004);
        chk({12'h000, irq_ack_o}, 13'h0000);
        @(posedge clock_i);
        irq_pend_i <= 1'b0;
      end
      op(6'h10, 13'h0200 + 13'(i));
      rchk(STK, {i == 9, 4'h0, 3'(i)});
    end
    wr(STK, 8'h00);
    rchk(STK, 8'h01);
    op(6'h04, 13'h0000);
    chk(13'(fetch_addr_o[12:4]), 13'h0020);
    rchk(STK, 8'h00);
    @(posedge clock_i);
    irq_pend_i <= 1'b1;
    op(6'h08, 13'h0004);
    chk({12'h000, irq_ack_o}, 13'h0001);
    chk(fetch_addr_o, 13'h0004);
    @(posedge clock_i);
    irq_pend_i <= 1'b0;
    rchk(STK, 8'h01);
    // enable low: pc and phase must hold still
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    #1 p = fetch_addr_o;
    v = {6'h00, phase_o};
    repeat (6) @(posedge clock_i);
    #1 chk(fetch_addr_o, p);
    chk({5'h00, v}, {11'h000, phase_o});
    clk_en_i <= 1'b1;
    report_and_stop;
  end
endmodule
bind pcs_prog_flow pcs_prog_flow_monitor mon (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_i),
  .irq_pend_i(irq_pend_i), .fetch_addr_o(fetch_addr_o), .fetch_o(fetch_o),
  .idle_cycle_o(idle_cycle_o), .irq_ack_o(irq_ack_o), .phase_o(phase_o));
